// *** pkg/abs_pkg.sv ***
// Shared constants and the state layout of the address and bus select decoder.
// Assumes a 16-bit processor address and one 40 MHz system clock.
package abs_pkg;

    // Address field positions.
    localparam int unsigned ABS_BLK_MSB = 15;
    localparam int unsigned ABS_BLK_LSB = 13;
    localparam int unsigned ABS_SEC_MSB = 12;
    localparam int unsigned ABS_SEC_LSB = 11;

    // Primary block numbers that carry local devices.
    localparam logic [2:0] ABS_BLK_LOW = 3'h0;
    localparam logic [2:0] ABS_BLK_SYS = 3'h1;
    localparam logic [2:0] ABS_BLK_ROM = 3'h7;

    // Secondary first-half select numbers.
    localparam logic [1:0] ABS_SEC_RAM    = 2'h0;
    localparam logic [1:0] ABS_SEC_SWITCH = 2'h2;
    localparam logic [1:0] ABS_SEC_SIG    = 2'h3;

    // Secondary second-half select numbers.
    localparam logic [1:0] ABS_SECB_LATCH  = 2'h0;
    localparam logic [1:0] ABS_SECB_SWITCH = 2'h1;

    // Last address of the on-chip processor RAM.
    localparam logic [15:0] ABS_CPU_RAM_LAST = 16'h007f;

    // Decoder output of a disabled two-to-four decoder.
    localparam logic [3:0] ABS_DEC_IDLE = 4'hf;

    typedef struct packed {
        logic [7:0] blk_sel_n;
        logic [3:0] sec_sel_n;
        logic       latch_write_sel_n;
        logic       switch_read_sel_n;
        logic       switch_reg_enable_n;
        logic       sig_analysis;
        logic       int_bus_en_n;
        logic       ext_bus_en_n;
        logic       ext_xcvr_en_n;
        logic       ext_bus_dir;
        logic       ext_vma;
        logic       ext_rw;
        logic       int_vma;
        logic       int_rw;
        logic       buffered_phase2_clk;
        logic       buffered_phase2_clk_n;
    } abs_state_s;

    localparam abs_state_s ABS_RESET_STATE = '{
        blk_sel_n:             8'hff,
        sec_sel_n:             4'hf,
        latch_write_sel_n:     1'h1,
        switch_read_sel_n:     1'h1,
        switch_reg_enable_n:   1'h1,
        sig_analysis:          1'h1,
        int_bus_en_n:          1'h1,
        ext_bus_en_n:          1'h1,
        ext_xcvr_en_n:         1'h1,
        ext_bus_dir:           1'h1,
        ext_vma:               1'h0,
        ext_rw:                1'h1,
        int_vma:               1'h0,
        int_rw:                1'h1,
        buffered_phase2_clk:   1'h0,
        buffered_phase2_clk_n: 1'h1
    };

endpackage : abs_pkg

// *** pkg/abs_dec_if.sv ***
// Carrier between the bus select decoder and one two-to-four decoder half.
// Assumes both ends are combinational and share the system clock domain.
`timescale 1ns/1ps
interface abs_dec_if;
    logic       en;
    logic [1:0] code;
    logic [3:0] y_n;

    modport dec  (input en, input code, output y_n);
    modport user (output en, output code, input y_n);
endinterface : abs_dec_if

// *** logic/abs_dec24.sv ***
// One half of a dual two-to-four decoder with an active-high enable given as en.
// Assumes the user registers the outputs; this half is purely combinational.
`timescale 1ns/1ps
module abs_dec24 (
    abs_dec_if.dec port_if
);

    always_comb begin
        if (port_if.en) begin
            port_if.y_n = ~(4'h1 << port_if.code);
        end else begin
            port_if.y_n = abs_pkg::ABS_DEC_IDLE;
        end
    end

endmodule : abs_dec24

// *** logic/abs_decoder.sv ***
// Address decode and data bus steering for an 8-bit processor board.
// Assumes address, qualifiers, phase clock and straps are synchronous to mclk.
`timescale 1ns/1ps
module abs_decoder (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [15:0] addr,
    input  wire logic        buffered_valid_mem_addr,
    input  wire logic        rw,
    input  wire logic        phase2_clk,
    input  wire logic        force_dis_n,
    input  wire logic        ext_dis_n,
    input  wire logic        ext_strap_inhibit,
    output logic      [7:0]  blk_sel_n,
    output logic      [3:0]  sec_sel_n,
    output logic             latch_write_sel_n,
    output logic             switch_read_sel_n,
    output logic             switch_reg_enable_n,
    output logic             sig_analysis,
    output logic             int_bus_en_n,
    output logic             ext_bus_en_n,
    output logic             ext_xcvr_en_n,
    output logic             ext_bus_dir,
    output logic             ext_vma,
    output logic             ext_rw,
    output logic             int_vma,
    output logic             int_rw,
    output logic             buffered_phase2_clk,
    output logic             buffered_phase2_clk_n
);

    abs_pkg::abs_state_s st_r;
    abs_pkg::abs_state_s st_nxt;

    abs_dec_if sec_a_if ();
    abs_dec_if sec_b_if ();

    logic [2:0] blk_code;
    logic [7:0] blk_dec_n;
    logic       vma;
    logic       phase_low;
    logic       cpu_ram_hit;
    logic       sec_sel_a2;
    logic       sig_region;
    logic       sw_read;
    logic       bus_kill;
    logic       local_hit;
    logic       ext_sel;
    logic       int_sel;

    assign vma       = buffered_valid_mem_addr;
    assign phase_low = ~phase2_clk;
    assign blk_code  = addr[abs_pkg::ABS_BLK_MSB:abs_pkg::ABS_BLK_LSB];

    // Only the valid-address qualifier enables the primary decoder.
    always_comb begin
        if (vma) begin
            blk_dec_n = ~(8'h01 << blk_code);
        end else begin
            blk_dec_n = 8'hff;
        end
    end

    // First secondary half runs for the whole 2000-3FFF block.
    assign sec_a_if.en   = ~blk_dec_n[abs_pkg::ABS_BLK_SYS];
    assign sec_a_if.code = addr[abs_pkg::ABS_SEC_MSB:abs_pkg::ABS_SEC_LSB];

    abs_dec24 u_sec_a (
        .port_if (sec_a_if)
    );

    assign sec_sel_a2 = sec_a_if.y_n[abs_pkg::ABS_SEC_SWITCH];
    assign sig_region = ~sec_a_if.y_n[abs_pkg::ABS_SEC_SIG];

    // Second half decodes the 3000 select with read/write, only in the low phase.
    assign sec_b_if.en   = phase_low;
    assign sec_b_if.code = {sec_sel_a2, rw};

    abs_dec24 u_sec_b (
        .port_if (sec_b_if)
    );

    assign sw_read     = ~sec_b_if.y_n[abs_pkg::ABS_SECB_SWITCH];
    assign cpu_ram_hit = vma && (addr <= abs_pkg::ABS_CPU_RAM_LAST);

    // Any of three causes removes both data buses.
    assign bus_kill = cpu_ram_hit || sw_read || !force_dis_n;

    // Blocks 2 to 6 stay outside this term; they belong to the external bank.
    assign local_hit = ~blk_dec_n[abs_pkg::ABS_BLK_LOW]
                     | ~blk_dec_n[abs_pkg::ABS_BLK_SYS]
                     | ~blk_dec_n[abs_pkg::ABS_BLK_ROM];

    assign int_sel = local_hit && !bus_kill;
    assign ext_sel = vma && !local_hit && !bus_kill && ext_dis_n;

    always_comb begin
        st_nxt = st_r;
        st_nxt.blk_sel_n           = blk_dec_n;
        st_nxt.sec_sel_n           = sec_a_if.y_n;
        st_nxt.latch_write_sel_n   = sec_b_if.y_n[abs_pkg::ABS_SECB_LATCH];
        st_nxt.switch_read_sel_n   = ~sw_read;
        st_nxt.switch_reg_enable_n = ~sw_read;
        // The strobe behaves as a set/reset latch cleared by leaving the region.
        st_nxt.sig_analysis = ~(sig_region && ((vma && !rw) || !st_r.sig_analysis));
        st_nxt.int_bus_en_n  = ~int_sel;
        st_nxt.ext_bus_en_n  = ~ext_sel;
        st_nxt.ext_xcvr_en_n = ~(ext_sel && phase_low && !ext_strap_inhibit);
        st_nxt.ext_bus_dir   = rw;
        st_nxt.ext_vma       = vma;
        st_nxt.ext_rw        = rw;
        st_nxt.int_vma       = vma;
        st_nxt.int_rw        = rw;
        st_nxt.buffered_phase2_clk   = phase2_clk;
        st_nxt.buffered_phase2_clk_n = ~phase2_clk;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= abs_pkg::ABS_RESET_STATE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign blk_sel_n             = st_r.blk_sel_n;
    assign sec_sel_n             = st_r.sec_sel_n;
    assign latch_write_sel_n     = st_r.latch_write_sel_n;
    assign switch_read_sel_n     = st_r.switch_read_sel_n;
    assign switch_reg_enable_n   = st_r.switch_reg_enable_n;
    assign sig_analysis          = st_r.sig_analysis;
    assign int_bus_en_n          = st_r.int_bus_en_n;
    assign ext_bus_en_n          = st_r.ext_bus_en_n;
    assign ext_xcvr_en_n         = st_r.ext_xcvr_en_n;
    assign ext_bus_dir           = st_r.ext_bus_dir;
    assign ext_vma               = st_r.ext_vma;
    assign ext_rw                = st_r.ext_rw;
    assign int_vma               = st_r.int_vma;
    assign int_rw                = st_r.int_rw;
    assign buffered_phase2_clk   = st_r.buffered_phase2_clk;
    assign buffered_phase2_clk_n = st_r.buffered_phase2_clk_n;

    default clocking cb @(posedge mclk);
    endclocking

    default disable iff (!rst_n);

    // Address tests seen by the checks below.
    logic in_rom;
    logic in_ram;
    logic in_switch;
    logic in_sig;
    logic in_local;

    assign in_rom    = blk_code == abs_pkg::ABS_BLK_ROM;
    assign in_ram    = {blk_code, addr[12:11]} == {abs_pkg::ABS_BLK_SYS, abs_pkg::ABS_SEC_RAM};
    assign in_switch = {blk_code, addr[12:11]} == {abs_pkg::ABS_BLK_SYS, abs_pkg::ABS_SEC_SWITCH};
    assign in_sig    = {blk_code, addr[12:11]} == {abs_pkg::ABS_BLK_SYS, abs_pkg::ABS_SEC_SIG};
    assign in_local  = in_rom || blk_code == abs_pkg::ABS_BLK_LOW || blk_code == abs_pkg::ABS_BLK_SYS;

    // Blocks 2 to 6 form the bank region that only the external bus reaches.
    logic in_bank;

    assign in_bank = blk_code >= 3'h2 && blk_code <= 3'h6;

    sequence sa_write_s;
        vma && !rw && in_sig;
    endsequence

    sequence sa_gone_s;
        !(vma && in_sig);
    endsequence

    sequence sw_read_s;
        vma && rw && in_switch && phase_low;
    endsequence

    sequence bank_access_s;
        vma && in_bank && force_dis_n && ext_dis_n;
    endsequence

    blk_decode_a : assert property (vma |=> blk_sel_n == ~(8'h01 << $past(blk_code)))
        else $error("block select does not match the address");

    blk_idle_a : assert property (!vma |=> blk_sel_n == 8'hff)
        else $error("block select active without valid address");

    rom_sel_a : assert property (vma && in_rom |=> !blk_sel_n[7] && ext_bus_en_n)
        else $error("program ROM select missing");

    sec_dec_a : assert property (vma && blk_code == abs_pkg::ABS_BLK_SYS
                                 |=> sec_sel_n == ~(4'h1 << $past(addr[12:11])))
        else $error("secondary select does not match the address");

    ram_sel_a : assert property (!(vma && in_ram) |=> sec_sel_n[0])
        else $error("system RAM selected outside its range");

    latch_wr_a : assert property (vma && !rw && in_switch && phase_low |=> !latch_write_sel_n ##0
                                  switch_read_sel_n)
        else $error("latch write select missing");

    latch_phase_a : assert property (phase2_clk |=> latch_write_sel_n && switch_read_sel_n)
        else $error("second half active in the high phase");

    sw_read_a : assert property (sw_read_s |=> !switch_read_sel_n && !switch_reg_enable_n
                                 && int_bus_en_n && ext_bus_en_n)
        else $error("switch read did not take the buses off");

    sa_set_a : assert property (sa_write_s |=> !sig_analysis)
        else $error("strobe did not fall on write");

    sa_hold_a : assert property (sa_write_s ##1 (vma && in_sig)[*2] |=> !sig_analysis)
        else $error("strobe released while address present");

    sa_clear_a : assert property (sa_gone_s |=> sig_analysis)
        else $error("strobe stayed low after the address left");

    force_kill_a : assert property (!force_dis_n |=> int_bus_en_n && ext_bus_en_n)
        else $error("forced disable ignored");

    bus_excl_a : assert property (!(!int_bus_en_n && !ext_bus_en_n))
        else $error("both buses enabled");

    local_int_a : assert property (vma && in_local && force_dis_n && !in_switch
                                   && addr > abs_pkg::ABS_CPU_RAM_LAST |=> !int_bus_en_n && ext_bus_en_n)
        else $error("local block did not select the internal bus");

    ext_dis_a : assert property (!ext_dis_n |=> ext_bus_en_n && ext_xcvr_en_n)
        else $error("disable input did not stop the external bus");

    strap_a : assert property (ext_strap_inhibit |=> ext_xcvr_en_n)
        else $error("strap did not hold the transceiver off");

    xcvr_gate_a : assert property (!ext_xcvr_en_n |-> !ext_bus_en_n && !$past(phase2_clk))
        else $error("transceiver enabled outside select and low phase");

    cpu_ram_a : assert property (vma && addr <= abs_pkg::ABS_CPU_RAM_LAST
                                 |=> int_bus_en_n && ext_bus_en_n)
        else $error("a bus enabled during on-chip RAM access");

    qual_copy_a : assert property (1'b1 |=> ext_vma == $past(vma) && int_vma == $past(vma)
                                   && ext_rw == $past(rw) && int_rw == $past(rw))
        else $error("qualifier copy differs from its source");

    clk_pair_a : assert property (buffered_phase2_clk != buffered_phase2_clk_n)
        else $error("clock copies not complementary");

    dir_a : assert property (1'b1 |=> ext_bus_dir == $past(rw))
        else $error("bus direction does not follow read/write");

    // The checks below pin each select to its own region and each gate to its own cause.
    bank_dark_a : assert property (vma && in_bank |=> int_bus_en_n)
        else $error("bank region enabled the internal bus");

    bank_ext_a : assert property (bank_access_s |=> !ext_bus_en_n && int_bus_en_n)
        else $error("bank region did not select the external bus");

    local_ext_a : assert property (vma && in_local |=> ext_bus_en_n)
        else $error("local block enabled the external bus");

    rom_idle_a : assert property (!(vma && in_rom) |=> blk_sel_n[7])
        else $error("program ROM selected outside its block");

    blk_onehot_a : assert property ($onehot0(~blk_sel_n))
        else $error("more than one block select active");

    vma_dark_a : assert property (!vma |=> int_bus_en_n && ext_bus_en_n)
        else $error("a bus enabled without valid address");

    vma_xcvr_a : assert property (!vma |=> ext_xcvr_en_n)
        else $error("transceiver enabled without valid address");

    sec_idle_a : assert property (!(vma && blk_code == abs_pkg::ABS_BLK_SYS)
                                  |=> sec_sel_n == abs_pkg::ABS_DEC_IDLE)
        else $error("secondary select active outside its region");

    sec_onehot_a : assert property ($onehot0(~sec_sel_n))
        else $error("more than one secondary select active");

    ram_on_a : assert property (vma && in_ram |=> !sec_sel_n[0])
        else $error("system RAM not selected");

    latch_read_a : assert property (rw |=> latch_write_sel_n)
        else $error("latch selected on a read");

    sw_write_a : assert property (!rw |=> switch_read_sel_n)
        else $error("switch register selected on a write");

    sw_pair_a : assert property (switch_reg_enable_n == switch_read_sel_n)
        else $error("switch enable differs from switch select");

    sw_xcvr_a : assert property (sw_read_s |=> ext_xcvr_en_n)
        else $error("transceiver enabled during switch read");

    half_excl_a : assert property (latch_write_sel_n || switch_read_sel_n)
        else $error("both second-half selects active");

    sa_read_a : assert property (sig_analysis && !(vma && !rw && in_sig) |=> sig_analysis)
        else $error("strobe fell without a write");

    force_xcvr_a : assert property (!force_dis_n |=> ext_xcvr_en_n)
        else $error("transceiver enabled under forced disable");

    ext_dis_int_a : assert property (!ext_dis_n && vma && in_bank |=> int_bus_en_n && ext_bus_en_n)
        else $error("disable input left a bus on in the bank region");

    strap_bus_a : assert property (bank_access_s ##0 ext_strap_inhibit
                                   |=> !ext_bus_en_n && ext_xcvr_en_n)
        else $error("strap changed the bus select or missed the transceiver");

    xcvr_on_a : assert property (bank_access_s ##0 (phase_low && !ext_strap_inhibit)
                                 |=> !ext_xcvr_en_n)
        else $error("transceiver not enabled in the low phase");

    xcvr_high_a : assert property (phase2_clk |=> ext_xcvr_en_n)
        else $error("transceiver enabled in the high phase");

    ram_xcvr_a : assert property (vma && addr <= abs_pkg::ABS_CPU_RAM_LAST |=> ext_xcvr_en_n)
        else $error("transceiver enabled during on-chip RAM access");

    clk_follow_a : assert property (1'b1 |=> buffered_phase2_clk == $past(phase2_clk)
                                    && buffered_phase2_clk_n == !$past(phase2_clk))
        else $error("clock copies do not follow the phase clock");

endmodule : abs_decoder

// *** verification/abs_cpu_model.sv ***
// Behavioural model of the processor that drives address, valid-address, read/write and phase clock.
// Assumes the caller invokes drive just after a falling mclk edge; the decoder samples on the rising edge.
`timescale 1ns/1ps
module abs_cpu_model (
    output logic [15:0] addr,
    output logic        vma,
    output logic        rw,
    output logic        phase2_clk
);
    logic [15:0] addr_last;

    initial begin
        addr       = 16'h0000;
        addr_last  = 16'h0000;
        vma        = 1'h0;
        rw         = 1'h1;
        phase2_clk = 1'h1;
    end

    // The address is not valid without vma, so the model shows the inverse of the last one.
    // Reads at the latch address only ever target the switches; the latch copy lives in RAM.
    task automatic drive(input logic [15:0] a, input logic v, input logic r, input logic ph);
        addr_last  = v ? a : addr_last;
        addr       = v ? a : ~addr_last;
        vma        = v;
        rw         = r;
        phase2_clk = ph;
    endtask : drive
endmodule : abs_cpu_model

// *** verification/tb_address_bus_select_decoder.sv ***
// Self-checking bench for the address and bus select decoder.
// Assumes outputs show the inputs of the previous rising mclk edge.
`timescale 1ns/1ps
module tb_address_bus_select_decoder;
    logic               mclk;
    logic               rst_n;
    logic [15:0]        addr;
    logic               vma;
    logic               rw;
    logic               ph2;
    logic               force_dis_n;
    logic               ext_dis_n;
    logic               strap;
    logic               sa_low;
    wire abs_pkg::abs_state_s obs;
    int                 fails;
    int                 n_compared;

    initial begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end

    abs_cpu_model cpu (.addr(addr), .vma(vma), .rw(rw), .phase2_clk(ph2));

    abs_decoder dut (
        .mclk(mclk), .rst_n(rst_n), .addr(addr), .buffered_valid_mem_addr(vma), .rw(rw),
        .phase2_clk(ph2), .force_dis_n(force_dis_n), .ext_dis_n(ext_dis_n), .ext_strap_inhibit(strap),
        .blk_sel_n(obs.blk_sel_n), .sec_sel_n(obs.sec_sel_n), .latch_write_sel_n(obs.latch_write_sel_n),
        .switch_read_sel_n(obs.switch_read_sel_n), .switch_reg_enable_n(obs.switch_reg_enable_n),
        .sig_analysis(obs.sig_analysis), .int_bus_en_n(obs.int_bus_en_n), .ext_bus_en_n(obs.ext_bus_en_n),
        .ext_xcvr_en_n(obs.ext_xcvr_en_n), .ext_bus_dir(obs.ext_bus_dir), .ext_vma(obs.ext_vma),
        .ext_rw(obs.ext_rw), .int_vma(obs.int_vma), .int_rw(obs.int_rw),
        .buffered_phase2_clk(obs.buffered_phase2_clk), .buffered_phase2_clk_n(obs.buffered_phase2_clk_n)
    );

    task automatic check(input abs_pkg::abs_state_s seen, input abs_pkg::abs_state_s exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t outputs %h expected %h at addr %h", $time, seen, exp, addr);
        end
    endtask : check

    function automatic abs_pkg::abs_state_s expect_out(input logic [15:0] a, input logic v, input logic r,
                                                       input logic ph, input logic fd, input logic ed,
                                                       input logic st, input logic sal);
        abs_pkg::abs_state_s e;
        logic                sec;
        logic                loc;
        logic                kill;
        logic                xs;
        e = abs_pkg::ABS_RESET_STATE;
        if (v) e.blk_sel_n = ~(8'h01 << a[15:13]);
        sec = v && (a[15:13] == 3'h1);
        if (sec) e.sec_sel_n = ~(4'h1 << a[12:11]);
        e.latch_write_sel_n   = !(sec && a[12:11] == 2'h2 && !r && !ph);
        e.switch_read_sel_n   = !(sec && a[12:11] == 2'h2 && r && !ph);
        e.switch_reg_enable_n = e.switch_read_sel_n;
        e.sig_analysis        = !(sec && a[12:11] == 2'h3 && (!r || sal));
        loc  = v && (a[15:13] inside {3'h0, 3'h1, 3'h7});
        kill = (v && a <= 16'h007f) || !e.switch_read_sel_n || !fd;
        xs   = v && !loc && !kill && ed;
        e.int_bus_en_n          = !(loc && !kill);
        e.ext_bus_en_n          = !xs;
        e.ext_xcvr_en_n         = !(xs && !ph && !st);
        e.ext_bus_dir           = r;
        e.ext_vma               = v;
        e.int_vma               = v;
        e.ext_rw                = r;
        e.int_rw                = r;
        e.buffered_phase2_clk   = ph;
        e.buffered_phase2_clk_n = !ph;
        return e;
    endfunction : expect_out

    // Called at a falling edge: drives one processor cycle and judges the result at the next falling edge.
    task automatic step(input logic [15:0] a, input logic v, input logic r, input logic ph);
        abs_pkg::abs_state_s e;
        cpu.drive(a, v, r, ph);
        #1;
        e = expect_out(addr, vma, rw, ph2, force_dis_n, ext_dis_n, strap, sa_low);
        @(negedge mclk);
        sa_low = !e.sig_analysis;
        check(obs, e);
    endtask : step

    task automatic t_blocks();
        for (int b = 0; b < 8; b++) begin
            step({b[2:0], 13'h0155}, 1'h1, 1'h1, 1'h0);
            step({b[2:0], 13'h1f00}, 1'h0, 1'h0, 1'h0);
        end
        $display("test blocks done");
    endtask : t_blocks

    task automatic t_secondary();
        for (int q = 0; q < 4; q++) begin
            for (int k = 0; k < 4; k++) begin
                step({5'h04 | q[4:0], 11'h000}, 1'h1, k[0], k[1]);
            end
        end
        $display("test secondary done");
    endtask : t_secondary

    task automatic t_sig();
        step(16'h3a00, 1'h1, 1'h1, 1'h0);
        step(16'h3800, 1'h1, 1'h0, 1'h0);
        step(16'h3a00, 1'h1, 1'h1, 1'h1);
        step(16'h3fff, 1'h1, 1'h1, 1'h0);
        step(16'h3000, 1'h1, 1'h1, 1'h1);
        step(16'h3800, 1'h1, 1'h1, 1'h0);
        step(16'h3800, 1'h1, 1'h0, 1'h1);
        step(16'h3800, 1'h0, 1'h1, 1'h0);
        $display("test signature done");
    endtask : t_sig

    task automatic t_cpu_ram();
        step(16'h0000, 1'h1, 1'h1, 1'h0);
        step(16'h007f, 1'h1, 1'h0, 1'h0);
        step(16'h0080, 1'h1, 1'h1, 1'h0);
        $display("test cpu ram done");
    endtask : t_cpu_ram

    task automatic t_disables();
        for (int k = 0; k < 3; k++) begin
            force_dis_n = (k != 0);
            ext_dis_n   = (k != 1);
            strap       = (k == 2);
            step(16'h8000, 1'h1, 1'h1, 1'h0);
            step(16'hc123, 1'h1, 1'h0, 1'h0);
            step(16'h2000, 1'h1, 1'h1, 1'h0);
        end
        force_dis_n = 1'h1;
        ext_dis_n   = 1'h1;
        strap       = 1'h0;
        $display("test disables done");
    endtask : t_disables

    // Resets in mid-run with the strobe low; the strobe must go high in reset and stay high after release.
    task automatic t_reset();
        cpu.drive(16'h3800, 1'h1, 1'h0, 1'h0);
        @(negedge mclk);
        rst_n = 1'h0;
        #1;
        check(obs, abs_pkg::ABS_RESET_STATE);
        @(negedge mclk);
        rst_n  = 1'h1;
        sa_low = 1'h0;
        step(16'h3800, 1'h1, 1'h1, 1'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_xcvr();
        step(16'h8000, 1'h1, 1'h1, 1'h1);
        step(16'h8000, 1'h1, 1'h1, 1'h0);
        step(16'hdfff, 1'h1, 1'h0, 1'h0);
        step(16'h4000, 1'h1, 1'h0, 1'h1);
        step(16'he000, 1'h1, 1'h1, 1'h0);
        $display("test transceiver done");
    endtask : t_xcvr

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        #(25 * 2000);
        fails++;
        end_sim();
    end

    initial begin
        fails       = 0;
        n_compared  = 0;
        sa_low      = 1'h0;
        rst_n       = 1'h0;
        force_dis_n = 1'h1;
        ext_dis_n   = 1'h1;
        strap       = 1'h0;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        check(obs, abs_pkg::ABS_RESET_STATE);
        rst_n = 1'h1;
        t_blocks();
        t_secondary();
        t_sig();
        t_cpu_ram();
        t_disables();
        t_reset();
        t_xcvr();
        end_sim();
    end
endmodule : tb_address_bus_select_decoder
